// file: hdl/delayed_pulse_counter_pkg.sv
// constants shared by the delayed pulse counter block
// assumes a 250 MHz system clock and AXI4-Lite register access
package delayed_pulse_counter_pkg;

    localparam int NUM_COUNTERS = 10;
    localparam int HALF_COUNTERS = 5;
    localparam int CLK_HZ = 250_000_000;

    // decade timebases: frequency in Hz, then clocks per tick
    localparam int TB1_HZ = 1_000_000;
    localparam int TB2_HZ = 100_000;
    localparam int TB3_HZ = 10_000;
    localparam int TB4_HZ = 1_000;
    localparam int TB5_HZ = 100;
    localparam int TB1_DIV = CLK_HZ / TB1_HZ;
    localparam int TB_STEP = 10;
    localparam logic [7:0] TB1_LAST = 8'(TB1_DIV - 1);
    localparam logic [3:0] DECADE_LAST = 4'(TB_STEP - 1);

    // timebase select codes
    localparam logic [3:0] TB_CHAIN = 4'h0;
    localparam logic [3:0] TB_INT_FIRST = 4'h1;
    localparam logic [3:0] TB_INT_LAST = 4'h5;
    localparam logic [3:0] TB_SRC_FIRST = 4'h6;
    localparam logic [3:0] TB_GATE_FIRST = 4'hB;

    // gating modes
    localparam logic [2:0] GATE_NONE = 3'h0;
    localparam logic [2:0] GATE_HIGH = 3'h1;
    localparam logic [2:0] GATE_LOW = 3'h2;
    localparam logic [2:0] GATE_RISE = 3'h3;
    localparam logic [2:0] GATE_FALL = 3'h4;

    // output drive codes on clear
    localparam logic [1:0] DRIVE_HIZ = 2'h0;
    localparam logic [1:0] DRIVE_LOW = 2'h1;
    localparam logic [1:0] DRIVE_HIGH = 2'h2;

    // register map, one block of four words per counter
    localparam logic [7:0] REG_CONFIG = 8'h00;
    localparam logic [7:0] REG_DELAY = 8'h04;
    localparam logic [7:0] REG_WIDTH = 8'h08;
    localparam logic [7:0] REG_CMD = 8'h0C;
    localparam int CTR_SHIFT = 4;
    localparam logic [11:0] MAP_LAST = 12'h09F;

    // config fields
    localparam int CF_TB_LSB = 0;
    localparam int CF_GATE_LSB = 4;
    localparam int CF_EDGE_BIT = 7;
    localparam int CF_TOGGLE_BIT = 8;
    localparam int CF_POL_BIT = 9;
    // command fields (write) and status fields (read)
    localparam int CMD_CLEAR_BIT = 0;
    localparam int CMD_PULSE_BIT = 1;
    localparam int CMD_MEAS_BIT = 2;
    localparam int CMD_REARM_BIT = 3;
    localparam int CMD_DRIVE_LSB = 4;
    localparam int ST_STATE_LSB = 0;
    localparam int ST_OUT_BIT = 4;
    localparam int ST_HOLD_LSB = 16;

    localparam logic [16:0] DELAY_MIN = 17'h0_0003;
    localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DELAY = 3'b001,
        ST_WIDTH = 3'b010,
        ST_DONE = 3'b011,
        ST_MEASURE = 3'b100
    } ctr_state_type;

endpackage

// file: hdl/delayed_pulse_counter.sv
// ten counters with selectable timebase, delayed pulse and measurement
// assumes pins are asynchronous and an AXI4-Lite master on clk
//
// The address map and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
module delayed_pulse_counter
    import delayed_pulse_counter_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [NUM_COUNTERS-1:0] source_in,
    input wire logic [NUM_COUNTERS-1:0] gate_in,
    output logic [NUM_COUNTERS-1:0] counter_out,
    output logic [NUM_COUNTERS-1:0] counter_out_en,
    output logic [NUM_COUNTERS-1:0] terminal_count,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // decode a byte address into counter index and word, valid if mapped
    function automatic logic addr_ok(input logic [11:0] a);
        return (a <= MAP_LAST) && (a[1:0] == 2'b00);
    endfunction
    function automatic logic [3:0] addr_ctr(input logic [11:0] a);
        return a[CTR_SHIFT+3:CTR_SHIFT];
    endfunction

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers: second stage and a delayed copy for edges
    logic [NUM_COUNTERS-1:0] src_m_q, src_s_q, src_p_q;
    logic [NUM_COUNTERS-1:0] gate_m_q, gate_s_q, gate_p_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            src_m_q <= '0;
            src_s_q <= '0;
            src_p_q <= '0;
            gate_m_q <= '0;
            gate_s_q <= '0;
            gate_p_q <= '0;
        end else if (clk_en) begin
            src_m_q <= source_in;
            src_s_q <= src_m_q;
            src_p_q <= src_s_q;
            gate_m_q <= gate_in;
            gate_s_q <= gate_m_q;
            gate_p_q <= gate_s_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // decade prescaler: 1 MHz tick then divide by ten four times
    logic [7:0] pre_q;
    logic [3:0] dec_q [1:4];
    logic [5:1] tick;
    assign tick[1] = (pre_q == TB1_LAST);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_q <= '0;
        end else if (clk_en) begin
            pre_q <= tick[1] ? 8'h00 : pre_q + 8'h01;
        end
    end
    genvar gd;
    generate
        for (gd = 1; gd <= 4; gd++) begin : g_decade
            assign tick[gd+1] = tick[gd] && (dec_q[gd] == DECADE_LAST);
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    dec_q[gd] <= '0;
                end else if (clk_en && tick[gd]) begin
                    dec_q[gd] <= (dec_q[gd] == DECADE_LAST) ? 4'h0
                                 : dec_q[gd] + 4'h1;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // register bus: write waits for both address and data
    logic [11:0] aw_q;
    logic [31:0] w_q;
    logic aw_have_q, w_have_q;
    logic wr_go;
    logic [3:0] wr_ctr;
    logic [7:0] wr_word;
    logic [31:0] cfg_q [NUM_COUNTERS];
    logic [16:0] delay_q [NUM_COUNTERS];
    logic [16:0] width_q [NUM_COUNTERS];
    logic [NUM_COUNTERS-1:0] cmd_clear, cmd_pulse, cmd_meas, cmd_rearm;
    assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
    assign wr_ctr = addr_ctr(aw_q);
    assign wr_word = {4'h0, aw_q[3:0]};
    assign s_axi_awready = !aw_have_q;
    assign s_axi_wready = !w_have_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_q <= '0;
            w_q <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_awvalid && !aw_have_q) begin
                aw_q <= s_axi_awaddr;
                aw_have_q <= 1'b1;
            end
            if (s_axi_wvalid && !w_have_q) begin
                w_q <= s_axi_wdata;
                w_have_q <= 1'b1;
            end
            if (wr_go) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= addr_ok(aw_q) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read: one cycle after the address is taken
    logic [31:0] rd_word [NUM_COUNTERS][4];
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= addr_ok(s_axi_araddr) ? RESP_OKAY
                               : RESP_SLVERR;
                s_axi_rdata <= addr_ok(s_axi_araddr)
                    ? rd_word[addr_ctr(s_axi_araddr)][s_axi_araddr[3:2]]
                    : 32'h0000_0000;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
    assign s_axi_arready = !s_axi_rvalid;

    ////////////////////////////////////////////////////////////////////
    // per-counter logic
    ctr_state_type state_q [NUM_COUNTERS];
    logic [15:0] cnt_q [NUM_COUNTERS];
    logic [15:0] hold_q [NUM_COUNTERS];
    logic [NUM_COUNTERS-1:0] armed_q, tog_q, lvl_q;
    logic [NUM_COUNTERS-1:0] tc_pulse;

    genvar gc;
    generate
        for (gc = 0; gc < NUM_COUNTERS; gc++) begin : g_ctr
            localparam int BANK = (gc < HALF_COUNTERS) ? 0 : HALF_COUNTERS;
            logic [3:0] tb;
            logic [2:0] gm;
            logic sel_lvl, sel_prev, tb_edge, gate_lvl, gate_edge;
            logic run, gated, wr_here;
            logic [16:0] load_d;
            assign wr_here = wr_go && addr_ok(aw_q) && (wr_ctr == 4'(gc));
            assign tb = cfg_q[gc][CF_TB_LSB +: 4];
            assign gm = cfg_q[gc][CF_GATE_LSB +: 3];
            assign cmd_clear[gc] = wr_here && (wr_word == REG_CMD)
                                   && w_q[CMD_CLEAR_BIT];
            assign cmd_pulse[gc] = wr_here && (wr_word == REG_CMD)
                                   && w_q[CMD_PULSE_BIT];
            assign cmd_meas[gc] = wr_here && (wr_word == REG_CMD)
                                  && w_q[CMD_MEAS_BIT];
            assign cmd_rearm[gc] = wr_here && (wr_word == REG_CMD)
                                   && w_q[CMD_REARM_BIT];

            // count event selection by timebase code
            always_comb begin
                sel_lvl = src_s_q[BANK + int'(tb - TB_SRC_FIRST) % 5];
                sel_prev = src_p_q[BANK + int'(tb - TB_SRC_FIRST) % 5];
                if (tb >= TB_GATE_FIRST) begin
                    sel_lvl = gate_s_q[BANK + int'(tb - TB_GATE_FIRST)];
                    sel_prev = gate_p_q[BANK + int'(tb - TB_GATE_FIRST)];
                end
            end
            always_comb begin
                if (tb == TB_CHAIN) begin
                    // first counter has no lower neighbour and stalls
                    tb_edge = (gc > 0) ? tc_pulse[(gc+NUM_COUNTERS-1)
                              % NUM_COUNTERS] : 1'b0;
                end else if (tb <= TB_INT_LAST) begin
                    tb_edge = tick[tb - TB_INT_FIRST + 1];
                end else begin
                    // chosen edge of the external signal
                    tb_edge = cfg_q[gc][CF_EDGE_BIT] ? (!sel_lvl && sel_prev)
                              : (sel_lvl && !sel_prev);
                end
            end
            // gate as seen through the gating mode
            assign gate_lvl = (gm == GATE_LOW) ? !gate_s_q[gc] : gate_s_q[gc];
            assign gate_edge = (gm == GATE_FALL)
                ? (!gate_s_q[gc] && gate_p_q[gc])
                : (gate_s_q[gc] && !gate_p_q[gc]);
            assign gated = (gm == GATE_RISE) || (gm == GATE_FALL);
            // level gating runs only while active, edge gating once armed
            assign run = (gm == GATE_NONE) ? 1'b1
                         : gated ? armed_q[gc] : gate_lvl;
            assign tc_pulse[gc] = tb_edge && run && (cnt_q[gc] == 16'h0001)
                && ((state_q[gc] == ST_DELAY) || (state_q[gc] == ST_WIDTH));
            assign load_d = (state_q[gc] == ST_DELAY) ? width_q[gc]
                            : delay_q[gc];

            // configuration and count registers
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    cfg_q[gc] <= CONFIG_RESET;
                    delay_q[gc] <= DELAY_MIN;
                    width_q[gc] <= '0;
                end else if (clk_en && wr_here) begin
                    if (wr_word == REG_CONFIG)
                        cfg_q[gc] <= w_q;
                    if (wr_word == REG_DELAY)
                        delay_q[gc] <= w_q[16:0];
                    if (wr_word == REG_WIDTH)
                        width_q[gc] <= w_q[16:0];
                end
            end

            // sequencer: delay, width, done, measure
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    state_q[gc] <= ST_IDLE;
                    cnt_q[gc] <= '0;
                    hold_q[gc] <= '0;
                    armed_q[gc] <= 1'b0;
                    tog_q[gc] <= 1'b0;
                    lvl_q[gc] <= 1'b0;
                    counter_out_en[gc] <= 1'b0;
                    terminal_count[gc] <= 1'b0;
                end else if (clk_en) begin
                    terminal_count[gc] <= tc_pulse[gc];
                    if (gated && gate_edge)
                        armed_q[gc] <= 1'b1;
                    if (cmd_clear[gc]) begin
                        state_q[gc] <= ST_IDLE;
                        armed_q[gc] <= 1'b0;
                        tog_q[gc] <= 1'b0;
                        cnt_q[gc] <= '0;
                        lvl_q[gc] <= (w_q[CMD_DRIVE_LSB +: 2] == DRIVE_HIGH);
                        counter_out_en[gc] <=
                            (w_q[CMD_DRIVE_LSB +: 2] != DRIVE_HIZ);
                    end else if (cmd_pulse[gc] && state_q[gc] == ST_IDLE) begin
                        // 16-bit count of the 17-bit delay, 65536 wraps to 0 = full range
                        cnt_q[gc] <= delay_q[gc][15:0];
                        state_q[gc] <= ST_DELAY;
                        counter_out_en[gc] <= 1'b1;
                        lvl_q[gc] <= cfg_q[gc][CF_POL_BIT];
                    end else if (cmd_meas[gc] && state_q[gc] == ST_IDLE) begin
                        cnt_q[gc] <= '0;
                        state_q[gc] <= ST_MEASURE;
                        counter_out_en[gc] <= 1'b1;
                        lvl_q[gc] <= cfg_q[gc][CF_POL_BIT];
                    end else if (cmd_rearm[gc]) begin
                        // a rearm during a running pulse is dropped
                        if (state_q[gc] == ST_DONE) begin
                            cnt_q[gc] <= delay_q[gc][15:0];
                            state_q[gc] <= ST_DELAY;
                            armed_q[gc] <= 1'b0;
                            if (!cfg_q[gc][CF_TOGGLE_BIT])
                                lvl_q[gc] <= cfg_q[gc][CF_POL_BIT];
                        end
                    end else begin
                        unique case (state_q[gc])
                            ST_IDLE, ST_DONE: begin
                            end
                            ST_DELAY, ST_WIDTH: begin
                                if (tb_edge && run)
                                    cnt_q[gc] <= cnt_q[gc] - 16'h0001;
                                if (tc_pulse[gc]) begin
                                    // toggle and pulse type both flip the level
                                    lvl_q[gc] <= !lvl_q[gc];
                                    cnt_q[gc] <= load_d[15:0];
                                    if (state_q[gc] == ST_WIDTH)
                                        state_q[gc] <= ST_DONE;
                                    else if (width_q[gc] == 17'h0_0000)
                                        state_q[gc] <= ST_DONE;
                                    else
                                        state_q[gc] <= ST_WIDTH;
                                end
                            end
                            ST_MEASURE: begin
                                if (gated && gate_edge && armed_q[gc]) begin
                                    hold_q[gc] <= cnt_q[gc];
                                    cnt_q[gc] <= '0;
                                end else if (gm != GATE_NONE && !gated
                                             && !gate_lvl
                                             && cnt_q[gc] != 16'h0000) begin
                                    hold_q[gc] <= cnt_q[gc];
                                    cnt_q[gc] <= '0;
                                end else if (tb_edge && run) begin
                                    cnt_q[gc] <= cnt_q[gc] + 16'h0001;
                                end
                            end
                        endcase
                    end
                end
            end
            assign counter_out[gc] = lvl_q[gc];

            // readback words for this counter
            assign rd_word[gc][0] = cfg_q[gc];
            assign rd_word[gc][1] = {15'h0000, delay_q[gc]};
            assign rd_word[gc][2] = {15'h0000, width_q[gc]};
            assign rd_word[gc][3] = {hold_q[gc], 11'h000, lvl_q[gc],
                                     1'b0, state_q[gc]};
        end
    endgenerate

endmodule

// file: verification/dpc_monitor.sv
// checker for the delayed pulse counter, watching its top ports only
// assumes one clock domain with an async active-low reset
`timescale 1ns/1ps
module dpc_monitor
    import delayed_pulse_counter_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [NUM_COUNTERS-1:0] counter_out,
    input wire logic [NUM_COUNTERS-1:0] counter_out_en,
    input wire logic [NUM_COUNTERS-1:0] terminal_count,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // all checks share the one clock and its reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    //////////////////////////////////////////////////
    // bus handshake relations
    bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid lost");
    rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid lost");
    read_ready_a: assert property (s_axi_arready == !s_axi_rvalid)
        else $error("arready not tied to rvalid");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready &&
        clk_en |=> s_axi_rvalid) else $error("read answer late");
    // both halves land in the holding flags first, so bvalid is two late
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready && clk_en |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready &&
        clk_en && s_axi_araddr > MAP_LAST |=> s_axi_rresp == RESP_SLVERR
        && s_axi_rdata == '0) else $error("unmapped read answered");

    //////////////////////////////////////////////////
    // counter outputs
    reset_idle_a: assert property ($rose(rst_n) |->
        counter_out_en == '0 && !s_axi_bvalid && !s_axi_rvalid)
        else $error("not idle after reset");
    tc_single_a: assert property (|terminal_count |=>
        (terminal_count & $past(terminal_count)) == '0)
        else $error("terminal count longer than a cycle");
    freeze_hold_a: assert property (!clk_en |=> $stable(counter_out) &&
        $stable(counter_out_en) && $stable(s_axi_rvalid))
        else $error("state moved while frozen");
endmodule

// file: verification/dpc_far_side.sv
// model of the pins beyond the counters: count sources and gates
// assumes the bench calls its tasks from one process at a time
`timescale 1ns/1ps
module dpc_far_side
    import delayed_pulse_counter_pkg::*;
(
    input wire logic clk,
    output logic [NUM_COUNTERS-1:0] source_in,
    output logic [NUM_COUNTERS-1:0] gate_in
);
    // pins start low so no stray edge is seen after reset
    initial begin
        source_in = '0;
        gate_in = '0;
    end

    // pulses are 4 clocks wide so the two-flop synchroniser sees each
    task automatic pulses(input int ch, input int n);
        repeat (n) begin
            repeat (4) @(posedge clk);
            source_in[ch] <= 1'b1;
            repeat (4) @(posedge clk);
            source_in[ch] <= 1'b0;
        end
        repeat (6) @(posedge clk);
    endtask

    // gate level change, then time for it to cross into the block
    task automatic gate(input int ch, input logic v);
        @(posedge clk);
        gate_in[ch] <= v;
        repeat (8) @(posedge clk);
    endtask
endmodule

// file: verification/delayed_pulse_counter_tb.sv
// self-checking bench for the delayed pulse counter over AXI4-Lite
// assumes the far-side model drives every source and gate pin
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
    $display("wrong value at %0t: got %h", $time, g); end end
module delayed_pulse_counter_tb
    import delayed_pulse_counter_pkg::*;
    ;
    logic clk, rst_n, clk_en;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [NUM_COUNTERS-1:0] source_in, gate_in, counter_out;
    logic [NUM_COUNTERS-1:0] counter_out_en, terminal_count;
    int err_count, compares, cyc;
    int tc_n [NUM_COUNTERS];

    //////////////////////////////////////////////////
    // design and far side; wstrb is ignored by the design
    delayed_pulse_counter dut (.*, .s_axi_wstrb(4'hF));
    dpc_far_side far (.clk(clk), .source_in(source_in), .gate_in(gate_in));

    // 250 MHz clock
    always #2 clk = ~clk;

    // cycle ceiling and terminal count tally per counter
    always @(posedge clk) begin
        cyc++;
        for (int i = 0; i < NUM_COUNTERS; i++)
            if (terminal_count[i] === 1'b1) tc_n[i]++;
        if (cyc == 20000) begin
            err_count++;
            give_verdict();
        end
    end

    //////////////////////////////////////////////////
    // bus tasks: a clock edge passes first so no signal is set twice
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rdat = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    function automatic logic [11:0] ad(input int n, input logic [7:0] o);
        return 12'(n << CTR_SHIFT) + 12'(o);
    endfunction
    // commands get a few cycles for the outputs to follow
    task automatic cmd(input int n, input logic [31:0] v);
        wr(ad(n, REG_CMD), v);
        repeat (3) @(posedge clk);
    endtask
    task automatic stat(input int n);
        rd(ad(n, REG_CMD));
    endtask
    task automatic setup(input int n, input logic [31:0] cfg, dly, wid);
        cmd(n, 32'h0000_0011);
        wr(ad(n, REG_CONFIG), cfg);
        wr(ad(n, REG_DELAY), dly);
        wr(ad(n, REG_WIDTH), wid);
    endtask
    task automatic give_verdict();
        $display("compares %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    //////////////////////////////////////////////////
    // main sequence
    initial begin
        int t;
        t = 0;
        {clk, rst_n, clk_en} = 3'b001;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        `CHK(counter_out_en, '0);
        stat(0);
        `CHK(rdat[2:0], ST_IDLE);
        rd(12'h0A0);
        `CHK({rsp, rdat}, {RESP_SLVERR, 32'h0000_0000});
        wr(12'h0A0, 32'hFFFF_FFFF);
        `CHK(rsp, RESP_SLVERR);
        rd(ad(0, REG_CONFIG));
        `CHK(rdat, CONFIG_RESET);
        for (int c = 0; c < 3; c++) begin
            cmd(4, (32'(c) << CMD_DRIVE_LSB) | 32'h0000_0001);
            `CHK(counter_out_en[4], 1'(c != 0));
            if (c != 0) `CHK(counter_out[4], 1'(c == 2));
        end
        $display("reset and drive tests done");
        // source-timed pulse, early rearm refused, later one taken
        setup(0, {28'h0, TB_SRC_FIRST}, 32'h0000_0003, 32'h0000_0002);
        cmd(0, 32'h0000_0002);
        stat(0);
        `CHK(rdat[2:0], ST_DELAY);
        far.pulses(0, 1);
        cmd(0, 32'h0000_0008);
        far.pulses(0, 2);
        stat(0);
        `CHK({rdat[4], rdat[2:0]}, {1'b1, ST_WIDTH});
        far.pulses(0, 2);
        stat(0);
        `CHK({rdat[4], rdat[2:0]}, {1'b0, ST_DONE});
        `CHK(tc_n[0], 2);
        cmd(0, 32'h0000_0008);
        stat(0);
        `CHK(rdat[2:0], ST_DELAY);
        cmd(0, 32'h0000_0021);
        stat(0);
        `CHK({counter_out_en[0], counter_out[0], rdat[2:0]}, {2'b11, ST_IDLE});
        $display("pulse test done");
        // zero width with toggle: endless level, inverted by rearm
        setup(1, 32'h0000_0107, 32'h0000_0003, 32'h0000_0000);
        cmd(1, 32'h0000_0002);
        far.pulses(1, 7);
        `CHK(counter_out[1], 1'b1);
        cmd(1, 32'h0000_0008);
        far.pulses(1, 3);
        `CHK(counter_out[1], 1'b0);
        $display("zero width test done");
        // rising-edge gated period measurement, twice
        setup(2, 32'h0000_0038, 32'h0000_0003, 32'h0000_0000);
        cmd(2, 32'h0000_0004);
        stat(2);
        `CHK(rdat[2:0], ST_MEASURE);
        for (int k = 5; k > 0; k = k - 3) begin
            far.gate(2, 1'b1);
            far.pulses(2, k);
            far.gate(2, 1'b0);
            far.gate(2, 1'b1);
            stat(2);
            `CHK(rdat[31:16], 16'(k));
            far.gate(2, 1'b0);
        end
        $display("measure test done");
        // gate pin as count signal, upper-half source mapping
        setup(3, 32'h0000_000E, 32'h0000_0003, 32'h0000_0001);
        setup(6, 32'h0000_0006, 32'h0000_0003, 32'h0000_0001);
        cmd(3, 32'h0000_0002);
        cmd(6, 32'h0000_0002);
        for (int j = 0; j < 3; j++) begin
            far.gate(3, 1'b1);
            far.gate(3, 1'b0);
        end
        far.pulses(5, 3);
        stat(3);
        `CHK(rdat[2:0], ST_WIDTH);
        stat(6);
        `CHK(rdat[2:0], ST_WIDTH);
        $display("external timebase test done");
        // 1 MHz timebase: delay 3 plus width 1 ticks, one tick of slack
        setup(5, 32'h0000_0001, 32'h0000_0003, 32'h0000_0001);
        cmd(5, 32'h0000_0002);
        while (tc_n[5] < 2 && t < 2000) begin
            @(posedge clk);
            t++;
        end
        `CHK(t > 3 * TB1_DIV - 8 && t <= 4 * TB1_DIV, 1'b1);
        $display("internal timebase test done");
        // brief freeze with no traffic under way
        clk_en <= 1'b0;
        repeat (3) @(posedge clk);
        clk_en <= 1'b1;
        repeat (2) @(posedge clk);
        $display("freeze test done");
        give_verdict();
    end
endmodule

// checker beside the design's ports
bind delayed_pulse_counter dpc_monitor mon (.*);
